// ==== include/ceau_pkg.sv ====
package ceau_pkg;
  // Addressing modes
  typedef enum logic [2:0] {
    CEAU_M_REG, CEAU_M_IND, CEAU_M_DISP, CEAU_M_POSTINC, CEAU_M_PREDEC,
    CEAU_M_ABS, CEAU_M_IMM, CEAU_M_PCREL
  } ceau_mode_t;
  localparam logic [2:0] CEAU_M_MEMIND = 3'h7;
  // Operand sizes
  localparam logic [1:0] CEAU_SZ_B = 2'h0;
  localparam logic [1:0] CEAU_SZ_W = 2'h1;
  localparam logic [1:0] CEAU_SZ_L = 2'h2;
  // Extension lengths
  localparam logic [1:0] CEAU_EXT_8 = 2'h0;
  localparam logic [1:0] CEAU_EXT_16 = 2'h1;
  localparam logic [1:0] CEAU_EXT_24 = 2'h2;
  localparam logic [1:0] CEAU_EXT_32 = 2'h3;
  // Instruction classes
  localparam logic [1:0] CEAU_CL_ALU = 2'h0;
  localparam logic [1:0] CEAU_CL_XFER = 2'h1;
  localparam logic [1:0] CEAU_CL_BRANCH = 2'h2;
  localparam logic [1:0] CEAU_CL_BIT = 2'h3;
  // Field positions in the first instruction word
  localparam int CEAU_OP1_HI = 15;
  localparam int CEAU_OP1_LO = 12;
  localparam int CEAU_OP2_HI = 11;
  localparam int CEAU_OP2_LO = 8;
  localparam int CEAU_RS_HI = 7;
  localparam int CEAU_RS_LO = 4;
  localparam int CEAU_RD_HI = 3;
  localparam int CEAU_RD_LO = 0;
  localparam int CEAU_BITNUM_HI = 6;
  localparam int CEAU_BITNUM_LO = 4;
  localparam int CEAU_TRAPV_HI = 5;
  localparam int CEAU_TRAPV_LO = 4;
  localparam logic [7:0] CEAU_ZERO8 = 8'h00;
  localparam logic [15:0] CEAU_ONES16 = 16'hFFFF;
  localparam logic [23:0] CEAU_ONES24 = 24'hFFFFFF;
endpackage

// ==== hw/ceau_core.sv ====
// What this block does
// RULE_01 - Top four instruction bits always form the first operation field; second field optional.
// RULE_02 - Address register fields are 3 bits; data register fields 3 or 4 bits.
// RULE_03 - Extension word is 8, 16 or 32 bits: immediate, absolute or displacement.
// RULE_04 - Register direct selects 8-bit halves, 16-bit halves or 32-bit registers.
// RULE_05 - Register indirect code addresses keep low 24 bits, top byte zero.
// RULE_06 - Displacement mode adds 16-bit sign-extended or 32-bit displacement to register.
// RULE_07 - Post-increment uses register, then writes back register plus 1, 2 or 4.
// RULE_08 - Pre-decrement subtracts 1, 2 or 4 first, uses and stores result.
// RULE_09 - 8-bit absolute data address fills upper bits with ones.
// RULE_10 - 16-bit absolute sign-extends; 32-bit absolute reaches whole space.
// RULE_11 - 24-bit absolute is a code target with top byte zero.
// RULE_12 - Extract 2-bit trap vector selector and 3-bit bit number.
// RULE_13 - PC-relative sign-extends 8/16-bit displacement onto next PC, top byte zero.
// RULE_14 - Short branch spans -126..+128, long -32766..+32768 from the branch.
// RULE_15 - Memory indirect zero-extends 8-bit address, reads longword, top byte zero.
// RULE_16 - Odd word, longword or branch addresses have their lowest bit cleared.
// RULE_17 - ALU takes register and immediate only; transfers exclude PC-relative and indirect.
// RULE_18 - Reset low or watchdog overflow halts and masks; rising reset starts exception.
// RULE_19 - Exception state fetches vector then branches to it.
// RULE_20 - Release bus to another master on request; halt until returned.
// RULE_21 - Sleep instruction or hardware standby enters program stop state.
// RULE_22 - Only 24-bit advanced addressing exists; no 16-bit normal mode.
// RULE_23 - Effective addresses go to the memory bus as 24 bits.
`timescale 1ns/10ps
`default_nettype none
module ceau_core
  import ceau_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic chip_init_pin_n,
  input wire logic wdt_overflow,
  input wire logic hw_standby,
  input wire logic ins_valid,
  input wire logic [15:0] ins_word,
  input wire logic [31:0] ins_ext,
  input wire logic [1:0] ext_len,
  input wire logic [2:0] ea_mode,
  input wire logic memind_sel,
  input wire logic [1:0] op_size,
  input wire logic [1:0] ins_class,
  input wire logic code_target,
  input wire logic trap_instruction,
  input wire logic sleep_instruction,
  input wire logic [31:0] address_register_sel,
  input wire logic [31:0] next_pc,
  input wire logic vector_valid,
  input wire logic [31:0] vector_data,
  input wire logic bus_req,
  output logic [3:0] op_field1,
  output logic [3:0] op_field2,
  output logic [2:0] areg_index,
  output logic [3:0] dreg_index,
  output logic [1:0] reg_part,
  output logic [1:0] trap_vec_sel,
  output logic [2:0] bit_number,
  output logic [31:0] imm_data,
  output logic [23:0] ea_addr,
  output logic ea_valid,
  output logic [31:0] reg_wb_data,
  output logic reg_wb_en,
  output logic mode_illegal,
  output logic memind_fetch,
  output logic [23:0] branch_target,
  output logic branch_valid,
  output logic bus_grant,
  output logic int_mask,
  output logic cpu_running,
  output logic cpu_stopped
);
  typedef enum logic [2:0] {
    CEAU_ST_RESET, CEAU_ST_EXC, CEAU_ST_RUN, CEAU_ST_BUSREL, CEAU_ST_STOP, CEAU_ST_MEMIND
  } ceau_state_t;

  ceau_state_t state;
  ceau_state_t next_state;

  // --------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------
  function automatic logic [31:0] ceau_step(input logic [1:0] sz);
    case (sz)
      CEAU_SZ_W: ceau_step = 32'h00000002;
      CEAU_SZ_L: ceau_step = 32'h00000004;
      default: ceau_step = 32'h00000001;
    endcase
  endfunction

  // Clear bit 0 for word/longword or branch, and keep 24 bits
  function automatic logic [23:0] ceau_align(input logic [31:0] a, input logic even);
    ceau_align = {a[23:1], a[0] & ~even};
  endfunction

  function automatic logic [31:0] ceau_code(input logic [31:0] a);
    ceau_code = {CEAU_ZERO8, a[23:0]};
  endfunction

  // --------------------------------------------------------------
  // Effective address arithmetic
  // --------------------------------------------------------------
  logic [31:0] disp_ext;
  logic [31:0] abs_ext;
  logic [31:0] pcrel_sum;
  logic [31:0] next_ea;
  logic [31:0] next_wb;
  logic next_wb_en;
  logic next_illegal;
  logic even_req;
  logic is_mem;

  // RULE_06 displacement extend
  assign disp_ext = (ext_len == CEAU_EXT_32) ? ins_ext : {{16{ins_ext[15]}}, ins_ext[15:0]};

  // RULE_09 RULE_10 RULE_11 absolute forms
  always_comb begin
    unique case (ext_len)
      CEAU_EXT_8: abs_ext = {CEAU_ONES24, ins_ext[7:0]};
      CEAU_EXT_16: abs_ext = {{16{ins_ext[15]}}, ins_ext[15:0]};
      CEAU_EXT_24: abs_ext = {CEAU_ZERO8, ins_ext[23:0]};
      CEAU_EXT_32: abs_ext = ins_ext;
    endcase
  end

  // RULE_13 RULE_14 PC-relative target
  assign pcrel_sum = ceau_code(ceau_code(next_pc) + ((ext_len == CEAU_EXT_8) ?
                     {{24{ins_ext[7]}}, ins_ext[7:0]} : {{16{ins_ext[15]}}, ins_ext[15:0]}));

  assign even_req = (op_size != CEAU_SZ_B) || code_target;
  assign is_mem = (ea_mode != CEAU_M_REG) && (ea_mode != CEAU_M_IMM);

  always_comb begin
    next_ea = address_register_sel;
    next_wb = address_register_sel;
    next_wb_en = 1'b0;
    unique case (ea_mode)
      // RULE_05 indirect code address
      3'h1: next_ea = code_target ? ceau_code(address_register_sel) : address_register_sel;
      3'h2: next_ea = address_register_sel + disp_ext;
      // RULE_07 post-increment
      3'h3: begin
        next_ea = address_register_sel;
        next_wb = address_register_sel + ceau_step(op_size);
        next_wb_en = 1'b1;
      end
      // RULE_08 pre-decrement
      3'h4: begin
        next_ea = address_register_sel - ceau_step(op_size);
        next_wb = next_ea;
        next_wb_en = 1'b1;
      end
      3'h5: next_ea = abs_ext;
      3'h6: next_ea = ins_ext;
      3'h7: next_ea = memind_sel ? {24'h000000, ins_ext[7:0]} : pcrel_sum;
      default: next_ea = address_register_sel;
    endcase
  end

  // RULE_17 mode legality per class
  always_comb begin
    unique case (ins_class)
      CEAU_CL_ALU: next_illegal = is_mem;
      CEAU_CL_XFER: next_illegal = (ea_mode == CEAU_M_MEMIND);
      CEAU_CL_BIT: next_illegal = !((ea_mode == 3'h0) || (ea_mode == 3'h1) ||
                                    (ea_mode == 3'h5) || (ea_mode == 3'h6));
      CEAU_CL_BRANCH: next_illegal = !((ea_mode == 3'h7) || (ea_mode == 3'h1) ||
                                       (ea_mode == 3'h5));
    endcase
  end

  // --------------------------------------------------------------
  // Processing state control
  // --------------------------------------------------------------
  logic init_hold;
  assign init_hold = !chip_init_pin_n || wdt_overflow;
  logic accept;
  assign accept = (state == CEAU_ST_RUN) && ins_valid && !bus_req;

  always_comb begin
    next_state = state;
    unique case (state)
      // RULE_18 leave reset when pin rises
      CEAU_ST_RESET: next_state = CEAU_ST_EXC;
      // RULE_19 vector fetch then branch
      CEAU_ST_EXC: if (vector_valid) next_state = CEAU_ST_RUN;
      CEAU_ST_RUN: begin
        // RULE_20 release bus
        if (bus_req) next_state = CEAU_ST_BUSREL;
        // RULE_21 program stop entry
        else if (hw_standby || (ins_valid && sleep_instruction)) next_state = CEAU_ST_STOP;
        else if (ins_valid && trap_instruction) next_state = CEAU_ST_EXC;
        else if (accept && ea_mode == CEAU_M_MEMIND && memind_sel && !next_illegal)
          next_state = CEAU_ST_MEMIND;
      end
      CEAU_ST_BUSREL: if (!bus_req) next_state = CEAU_ST_RUN;
      CEAU_ST_STOP: if (!hw_standby) next_state = CEAU_ST_STOP;
      CEAU_ST_MEMIND: if (vector_valid) next_state = CEAU_ST_RUN;
    endcase
    if (init_hold) next_state = CEAU_ST_RESET;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= CEAU_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // RULE_18 RULE_20 RULE_21 status outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_mask <= 1'b1;
      bus_grant <= 1'b0;
      cpu_running <= 1'b0;
      cpu_stopped <= 1'b0;
    end else begin
      int_mask <= (next_state == CEAU_ST_RESET);
      bus_grant <= (next_state == CEAU_ST_BUSREL);
      cpu_running <= (next_state == CEAU_ST_RUN);
      cpu_stopped <= (next_state == CEAU_ST_STOP);
    end
  end

  // --------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------
  // RULE_01 RULE_02 RULE_04 RULE_12 field extraction
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_field1 <= 4'h0;
      op_field2 <= 4'h0;
      areg_index <= 3'h0;
      dreg_index <= 4'h0;
      reg_part <= 2'h0;
      trap_vec_sel <= 2'h0;
      bit_number <= 3'h0;
    end else if (accept) begin
      op_field1 <= ins_word[CEAU_OP1_HI:CEAU_OP1_LO];
      op_field2 <= ins_word[CEAU_OP2_HI:CEAU_OP2_LO];
      areg_index <= ins_word[CEAU_RD_HI-1:CEAU_RD_LO];
      dreg_index <= ins_word[CEAU_RD_HI:CEAU_RD_LO];
      reg_part <= op_size;
      trap_vec_sel <= ins_word[CEAU_TRAPV_HI:CEAU_TRAPV_LO];
      bit_number <= ins_word[CEAU_BITNUM_HI:CEAU_BITNUM_LO];
    end
  end

  // --------------------------------------------------------------
  // Address and write-back outputs
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ea_addr <= 24'h000000;
      ea_valid <= 1'b0;
      imm_data <= 32'h00000000;
      reg_wb_data <= 32'h00000000;
      reg_wb_en <= 1'b0;
      mode_illegal <= 1'b0;
      memind_fetch <= 1'b0;
    end else begin
      // RULE_03 immediate extension
      imm_data <= accept ? ins_ext : imm_data;
      // RULE_16 RULE_22 RULE_23 aligned 24-bit bus address
      ea_addr <= accept ? ceau_align(next_ea, even_req || memind_sel) : ea_addr;
      ea_valid <= accept && is_mem && !next_illegal;
      reg_wb_data <= accept ? next_wb : reg_wb_data;
      reg_wb_en <= accept && next_wb_en && !next_illegal;
      mode_illegal <= accept && next_illegal;
      memind_fetch <= accept && ea_mode == CEAU_M_MEMIND && memind_sel && !next_illegal;
    end
  end

  // RULE_15 RULE_19 branch targets, top byte forced zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      branch_target <= 24'h000000;
      branch_valid <= 1'b0;
    end else if ((state == CEAU_ST_EXC || state == CEAU_ST_MEMIND) && vector_valid
                 && !init_hold) begin
      branch_target <= ceau_align(ceau_code(vector_data), 1'b1);
      branch_valid <= 1'b1;
    end else if (accept && ins_class == CEAU_CL_BRANCH && !next_illegal && !memind_sel) begin
      branch_target <= ceau_align(next_ea, 1'b1);
      branch_valid <= 1'b1;
    end else begin
      branch_valid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  // RULE_07 post-increment step
  AST_POSTINC: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_07
    (accept && ea_mode == 3'h3 && ins_class == CEAU_CL_XFER) |=>
    reg_wb_en && reg_wb_data == $past(address_register_sel) + $past(ceau_step(op_size)))
    else $error("post-increment write-back wrong");
  AST_PREDEC: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_08
    (accept && ea_mode == 3'h4 && ins_class == CEAU_CL_XFER) |=>
    reg_wb_data[23:1] == ea_addr[23:1])
    else $error("pre-decrement address differs from write-back");
  AST_ABS8: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_09
    (accept && ea_mode == 3'h5 && ext_len == CEAU_EXT_8 && op_size == CEAU_SZ_B
     && !code_target) |=> ea_addr[23:8] == CEAU_ONES16)
    else $error("8-bit absolute not in top page");
  AST_EVEN: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_16
    branch_valid |-> !branch_target[0])
    else $error("odd branch target");
  AST_RESET: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_18
    !chip_init_pin_n |=> int_mask && !cpu_running)
    else $error("reset did not halt and mask");
  AST_BUSREL: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_20
    (cpu_running && bus_req && chip_init_pin_n && !wdt_overflow) |=> bus_grant)
    else $error("bus not released");
  AST_NOGRANT: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_20
    bus_grant |-> !ea_valid && !reg_wb_en)
    else $error("activity while bus released");
  AST_SLEEP: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_21
    (cpu_running && hw_standby && !bus_req && chip_init_pin_n && !wdt_overflow)
    |=> cpu_stopped)
    else $error("standby did not stop");
  AST_ALU: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_17
    (accept && ins_class == CEAU_CL_ALU && is_mem) |=> mode_illegal && !ea_valid)
    else $error("ALU memory mode accepted");
  COV_BUSREL: cover property (@(posedge core_clk) disable iff (!reset_n) bus_grant);
  COV_MEMIND: cover property (@(posedge core_clk) disable iff (!reset_n) memind_fetch);
  COV_STOP: cover property (@(posedge core_clk) disable iff (!reset_n) cpu_stopped);
endmodule
`default_nettype wire

// ==== verification/ceau_bus_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module ceau_bus_partner (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fetch,
  input wire logic [3:0] lat,
  input wire logic [31:0] vdata,
  input wire logic want_bus,
  input wire logic bus_grant,
  output logic vector_valid,
  output logic [31:0] vector_data,
  output logic bus_req
);
  logic [4:0] cnt;
  logic [2:0] hold;
  // --------------------------------
  // Longword read answers
  // --------------------------------
  // vector longword reads
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 5'h00;
      vector_valid <= 1'b0;
      vector_data <= 32'h0;
    end else begin
      vector_valid <= (cnt == 5'h01);
      // Idle data bus toggles so a stale value never looks valid
      vector_data <= (cnt == 5'h01) ? vdata : ~vector_data;
      if (fetch) cnt <= {1'b0, lat} + 5'h01;
      else if (cnt != 5'h00) cnt <= cnt - 5'h01;
    end
  end
  // --------------------------------
  // Second bus master
  // --------------------------------
  // use bus only once granted
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_req <= 1'b0;
      hold <= 3'h0;
    end else if (!bus_req) begin
      bus_req <= want_bus;
    end else if (bus_grant) begin
      hold <= hold + 3'h1;
      if (hold == 3'h3) begin
        bus_req <= 1'b0;
        hold <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_cpu_effective_address_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_effective_address_unit import ceau_pkg::*; ;
  logic core_clk = 1'b0, reset_n, chip_init_pin_n, wdt_overflow, hw_standby, ins_valid;
  logic [15:0] ins_word, w16;
  logic [31:0] ins_ext, address_register_sel, next_pc, vector_data, vd, imm_data, reg_wb_data;
  logic [31:0] x32;
  logic [1:0] ext_len, op_size, ins_class, reg_part, trap_vec_sel;
  logic [2:0] ea_mode, areg_index, bit_number;
  logic memind_sel, code_target, trap_instruction, sleep_instruction, vector_valid, bus_req;
  logic [3:0] op_field1, op_field2, dreg_index, lat;
  logic [23:0] ea_addr, branch_target;
  logic ea_valid, reg_wb_en, mode_illegal, memind_fetch, branch_valid, bus_grant, int_mask;
  logic cpu_running, cpu_stopped, vec_go, want_bus;
  logic [31:0] q_ea[$], q_wb[$], q_br[$], q_mf[$];
  int err_count = 0, n_compared = 0, n_ill = 0, i;
  always #5 core_clk = ~core_clk;
  ceau_core DUT (.core_clk, .reset_n, .chip_init_pin_n, .wdt_overflow, .hw_standby,
    .ins_valid, .ins_word, .ins_ext, .ext_len, .ea_mode, .memind_sel, .op_size, .ins_class,
    .code_target, .trap_instruction, .sleep_instruction, .address_register_sel, .next_pc,
    .vector_valid, .vector_data, .bus_req, .op_field1, .op_field2, .areg_index, .dreg_index,
    .reg_part, .trap_vec_sel, .bit_number, .imm_data, .ea_addr, .ea_valid, .reg_wb_data,
    .reg_wb_en, .mode_illegal, .memind_fetch, .branch_target, .branch_valid, .bus_grant,
    .int_mask, .cpu_running, .cpu_stopped);
  ceau_bus_partner u_partner (.core_clk, .reset_n, .fetch(memind_fetch | vec_go), .lat,
    .vdata(vd), .want_bus, .bus_grant, .vector_valid, .vector_data, .bus_req);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic issue(input logic [15:0] w, input logic [31:0] x, input logic [1:0] len,
    input logic [2:0] m, input logic ms, input logic [1:0] sz, input logic [1:0] cl,
    input logic ct, input logic tr, input logic sl);
    logic [31:0] r, a, inc, pc;
    logic [23:0] ea;
    r = $urandom();
    pc = $urandom();
    inc = (sz == CEAU_SZ_B) ? 32'h1 : (sz == CEAU_SZ_W) ? 32'h2 : 32'h4;
    a = r;
    case (m)
      3'h2: a = (len == CEAU_EXT_16) ? r + {{16{x[15]}}, x[15:0]} : r + x;
      3'h4: a = r - inc;
      3'h5: a = (len == CEAU_EXT_8) ? {24'hFFFFFF, x[7:0]} :
        (len == CEAU_EXT_16) ? {{16{x[15]}}, x[15:0]} : x;
      3'h7: a = ms ? {24'h000000, x[7:0]} :
        pc + ((len == CEAU_EXT_8) ? {{24{x[7]}}, x[7:0]} : {{16{x[15]}}, x[15:0]});
      default: ;
    endcase
    ea = a[23:0];
    if (sz != CEAU_SZ_B || ct || ms) ea[0] = 1'b0;
    if (cl == CEAU_CL_ALU && !(m inside {3'h0, 3'h6})) n_ill++;
    else if (cl == CEAU_CL_XFER && m == 3'h7) n_ill++;
    else if (cl == CEAU_CL_BRANCH && !(m inside {3'h1, 3'h5, 3'h7})) n_ill++;
    else if (cl == CEAU_CL_BIT && !(m inside {3'h0, 3'h1, 3'h5, 3'h6})) n_ill++;
    else if (m != 3'h0 && m != 3'h6) begin
      q_ea.push_back({8'h00, ea});
      if (m == 3'h7 && ms) q_mf.push_back({8'h00, ea});
      if (m == 3'h7 && ms) q_br.push_back({8'h00, vd[23:1], 1'b0});
      if (cl == CEAU_CL_BRANCH && !ms) q_br.push_back({8'h00, a[23:1], 1'b0});
      if (m == 3'h3) q_wb.push_back(r + inc);
      if (m == 3'h4) q_wb.push_back(a);
    end
    @(posedge core_clk);
    ins_valid <= 1'b1;
    ins_word <= w;
    ins_ext <= x;
    ext_len <= len;
    ea_mode <= m;
    memind_sel <= ms;
    op_size <= sz;
    ins_class <= cl;
    code_target <= ct;
    trap_instruction <= tr;
    sleep_instruction <= sl;
    address_register_sel <= r;
    next_pc <= pc;
  endtask
  task automatic idle();
    @(posedge core_clk);
    ins_valid <= 1'b0;
    trap_instruction <= 1'b0;
    sleep_instruction <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic boot();
    q_br.push_back({8'h00, vd[23:1], 1'b0});
    @(posedge core_clk);
    vec_go <= 1'b1;
    @(posedge core_clk);
    vec_go <= 1'b0;
    for (int k = 0; k < 20 && cpu_running !== 1'b1; k++) @(posedge core_clk) #1;
    chk("cpu_running", 1, cpu_running);
  endtask
  task automatic ign();
    issue(16'h0, 32'h0, CEAU_EXT_32, 3'h7, 1'b1, CEAU_SZ_L, CEAU_CL_BRANCH, 1'b0, 1'b0, 1'b0);
    void'(q_mf.pop_back());
    void'(q_br.pop_back());
    void'(q_ea.pop_back());
    idle();
  endtask
  always @(posedge core_clk) if (reset_n === 1'b1) begin
    if (ea_valid === 1'b1) chk("ea_addr", q_ea.size() ? q_ea.pop_front() : 32'hX, ea_addr);
    if (reg_wb_en === 1'b1) chk("wb_data", q_wb.size() ? q_wb.pop_front() : 32'hX, reg_wb_data);
    if (branch_valid === 1'b1) chk("br_tgt", q_br.size() ? q_br.pop_front() : 32'hX, branch_target);
    if (memind_fetch === 1'b1) chk("mi_addr", q_mf.size() ? q_mf.pop_front() : 32'hX, ea_addr);
    if (mode_illegal === 1'b1) begin
      chk("illegal", 1, n_ill > 0);
      n_ill--;
    end
  end
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    {reset_n, wdt_overflow, hw_standby, ins_valid, ins_word, ins_ext, ext_len, ea_mode} = '0;
    {memind_sel, op_size, ins_class, code_target, trap_instruction, sleep_instruction} = '0;
    {address_register_sel, next_pc, vd, lat, vec_go, want_bus} = '0;
    chip_init_pin_n = 1'b1;
    void'($urandom(38));
    @(posedge core_clk) #1;
    chk("int_mask", 1, int_mask);
    @(posedge core_clk);
    reset_n <= 1'b1;
    boot();
    for (i = 0; i < 3; i++) begin
      issue($urandom(), $urandom(), CEAU_EXT_32, 3'h1, 1'b0, i[1:0], CEAU_CL_XFER, i == 0, 0, 0);
      issue($urandom(), $urandom(), CEAU_EXT_32, 3'h3, 1'b0, i[1:0], CEAU_CL_XFER, 0, 0, 0);
      issue($urandom(), $urandom(), CEAU_EXT_32, 3'h4, 1'b0, i[1:0], CEAU_CL_XFER, 0, 0, 0);
      issue($urandom(), $urandom(), CEAU_EXT_16, 3'h2, 1'b0, i[1:0], CEAU_CL_XFER, 0, 0, 0);
      issue($urandom(), $urandom(), CEAU_EXT_32, 3'h2, 1'b0, i[1:0], CEAU_CL_XFER, 0, 0, 0);
    end
    for (i = 0; i < 8; i++)
      issue($urandom(), $urandom(), i[1:0], 3'h5, 1'b0, i[1:0] == 2'h0 ? CEAU_SZ_B : CEAU_SZ_W,
        CEAU_CL_XFER, i[1:0] == CEAU_EXT_24, 0, 0);
    issue($urandom(), 32'h80, CEAU_EXT_8, 3'h7, 1'b0, CEAU_SZ_W, CEAU_CL_BRANCH, 0, 0, 0);
    issue($urandom(), $urandom(), CEAU_EXT_16, 3'h7, 1'b0, CEAU_SZ_W, CEAU_CL_BRANCH, 0, 0, 0);
    issue($urandom(), 32'h0, CEAU_EXT_32, 3'h2, 1'b0, CEAU_SZ_W, CEAU_CL_ALU, 0, 0, 0);
    issue($urandom(), 32'h0, CEAU_EXT_8, 3'h7, 1'b1, CEAU_SZ_L, CEAU_CL_XFER, 0, 0, 0);
    issue($urandom(), 32'h0, CEAU_EXT_32, 3'h3, 1'b0, CEAU_SZ_W, CEAU_CL_BRANCH, 0, 0, 0);
    idle();
    for (i = 0; i < 4; i++) begin
      w16 = $urandom();
      x32 = $urandom();
      issue(w16, x32, CEAU_EXT_32, 3'h1, 1'b0, CEAU_SZ_L, CEAU_CL_BIT, 0, 0, 0);
      idle();
      chk("op1", w16[15:12], op_field1);
      chk("op2", w16[11:8], op_field2);
      chk("areg", w16[2:0], areg_index);
      chk("dreg", w16[3:0], dreg_index);
      chk("part", CEAU_SZ_L, reg_part);
      chk("trapv", w16[5:4], trap_vec_sel);
      chk("bitno", w16[6:4], bit_number);
      chk("imm", x32, imm_data);
    end
    vd = $urandom();
    lat = 4'h5;
    issue($urandom(), {24'h0, 8'hFB}, CEAU_EXT_8, 3'h7, 1'b1, CEAU_SZ_L, CEAU_CL_BRANCH, 0, 0, 0);
    idle();
    repeat (8) @(posedge core_clk);
    lat = 4'h0;
    want_bus <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("bus_grant", 1, bus_grant);
    chk("run_held", 0, cpu_running);
    want_bus <= 1'b0;
    ign();
    repeat (6) @(posedge core_clk) #1;
    chk("bus_back", 1, {bus_grant, cpu_running});
    issue($urandom(), 0, CEAU_EXT_32, 3'h0, 1'b0, CEAU_SZ_B, CEAU_CL_ALU, 0, 1, 0);
    idle();
    chk("trap_exc", 0, cpu_running);
    boot();
    for (i = 0; i < 2; i++) begin
      @(posedge core_clk);
      if (i == 0) wdt_overflow <= 1'b1;
      else chip_init_pin_n <= 1'b0;
      repeat (2) @(posedge core_clk) #1;
      chk("rst_state", 2, {int_mask, cpu_running});
      ign();
      @(posedge core_clk);
      wdt_overflow <= 1'b0;
      chip_init_pin_n <= 1'b1;
      boot();
    end
    issue($urandom(), 0, CEAU_EXT_32, 3'h0, 1'b0, CEAU_SZ_B, CEAU_CL_ALU, 0, 0, 1);
    idle();
    chk("sleep", 1, cpu_stopped);
    ign();
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    boot();
    @(posedge core_clk);
    hw_standby <= 1'b1;
    repeat (3) @(posedge core_clk) #1;
    chk("standby", 1, cpu_stopped);
    chk("pending", 0, q_ea.size() + q_wb.size() + q_br.size() + q_mf.size() + n_ill);
    give_verdict();
  end
endmodule
`default_nettype wire
